/* pwdt_pkg.sv */
// watchdog constants package plus the prescaler leaf module
// assumes a single synchronous clock domain and an active-low asynchronous reset
`timescale 1ns/10ps

package pwdt_pkg;
   // register byte offsets on the bus
   localparam logic [7:0] PWDT_OFF_CONFIG  = 8'h00;   // reload byte and prescale select
   localparam logic [7:0] PWDT_OFF_CONTROL = 8'h04;   // refresh bits, flag, enable
   localparam logic [7:0] PWDT_OFF_COUNT   = 8'h08;   // live counter, read only
   // config field positions
   localparam int          PWDT_CFG_RELOAD_LSB = 0;   // upper_byte_reload occupies [7:0]
   localparam int          PWDT_CFG_PRESCALE   = 8;   // prescale_select
   // control field positions
   localparam int          PWDT_CTL_ARM        = 0;   // refresh_arm_bit
   localparam int          PWDT_CTL_START      = 1;   // refresh_start_bit, reads zero
   localparam int          PWDT_CTL_FLAG       = 2;   // watchdog_reset_flag, write one clears
   localparam int          PWDT_CTL_ENABLED    = 3;   // enable status, read only
   localparam int          PWDT_CTL_DISABLE    = 4;   // write one turns the watchdog off
   // reset values
   localparam logic [7:0]  PWDT_RELOAD_RST   = 8'h00;
   localparam logic        PWDT_PRESCALE_RST = 1'b0;
   localparam logic [15:0] PWDT_COUNT_RST    = 16'h0000;
   localparam logic [15:0] PWDT_COUNT_TOP    = 16'hffff;   // wrap point
   localparam logic [7:0]  PWDT_LOW_CLEAR    = 8'h00;
   // prescaler terminal counts (divide minus one)
   localparam logic [6:0]  PWDT_DIV_FAST_LAST = 7'h01;     // divide by 2
   localparam logic [6:0]  PWDT_DIV_SLOW_LAST = 7'h7f;     // divide by 128
   // internal reset pulse length, last index of an 8 cycle pulse
   localparam logic [3:0]  PWDT_PULSE_LAST = 4'h7;
   // timing: figures quoted for a 40 MHz reference clock
   localparam int PWDT_CLK_PERIOD_NS = 40;                 // our own clock, 25 MHz
   localparam int PWDT_REF_CLK_MHZ   = 40;
   localparam int PWDT_MIN_PERIOD_NS = 12800;              // 12.8 us
   localparam int PWDT_MAX_PERIOD_NS = 819200;             // 819.2 us
   localparam int PWDT_MIN_PERIOD_CYC = (PWDT_MIN_PERIOD_NS * PWDT_REF_CLK_MHZ) / 1000;
   localparam int PWDT_MAX_PERIOD_CYC = (PWDT_MAX_PERIOD_NS * PWDT_REF_CLK_MHZ) / 1000;
   // watchdog states, one-hot
   typedef enum logic [2:0] {
      PWDT_ACTIVE = 3'b001,
      PWDT_OFF    = 3'b010,
      PWDT_FIRE   = 3'b100
   } pwdt_state_t;
endpackage

// prescaler: one-cycle tick every 2 or 128 clocks, restartable and freezable
module pwdt_prescaler
   import pwdt_pkg::*;
(
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic clear,    // restart the division from zero
   input  wire logic hold,     // freeze, used in idle and power-down
   input  wire logic slow,     // high selects divide by 128
   output logic      tick
);
   logic [6:0] div_q;          // running division count
   logic [6:0] div_d;
   logic [6:0] last;           // terminal value for the chosen ratio

   // next count; clear beats hold so a service always restarts cleanly
   always_comb begin
      last  = slow ? PWDT_DIV_SLOW_LAST : PWDT_DIV_FAST_LAST;
      tick  = !clear && !hold && (div_q >= last);   // >= copes with a ratio change mid-count
      div_d = div_q;
      if (clear) begin
         div_d = 7'h00;
      end else if (tick) begin
         div_d = 7'h00;
      end else if (!hold) begin
         div_d = div_q + 7'h01;
      end
   end

   // count register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         div_q <= 7'h00;
      end else begin
         div_q <= div_d;
      end
   end
endmodule

/* pwdt_top.sv */
// programmable watchdog with an AHB-Lite register slave
// assumes it is the only slave behind hready, and that RST_N is the external reset
//
// Our own choices: the AHB-Lite slave port and the address map.
`timescale 1ns/10ps

// What this block does
// - sixteen-bit counter advanced through 2/128 prescaler
// - service loads reload value into upper byte
// - service clears counter lower byte
// - missed service triggers internal system reset
// - period from 12.8 us to 209.7 ms at 40 MHz
// - enabled after reset; cannot re-enable once off
// - service only on arm then start writes
// - expiry sets readable watchdog reset flag
// - counter halts in idle or power-down
module pwdt_top
   import pwdt_pkg::*;
(
   input  wire logic        CLK,
   input  wire logic        RST_N,
   input  wire logic        HSEL,
   input  wire logic [31:0] HADDR,
   input  wire logic [1:0]  HTRANS,
   input  wire logic        HWRITE,
   input  wire logic [2:0]  HSIZE,
   input  wire logic [31:0] HWDATA,
   input  wire logic        HREADY,
   output logic      [31:0] HRDATA,
   output logic             HREADYOUT,
   output logic             HRESP,
   input  wire logic        IDLE_MODE,
   input  wire logic        POWER_DOWN,
   output logic             WATCHDOG_RESET_OUT
);
   // bus data phase state
   logic        wr_ph_q, wr_ph_d;        // a word write is in its data phase
   logic [7:0]  addr_q, addr_d;          // its offset
   logic [31:0] rdata_q, rdata_d;        // read data, registered at the address phase
   // watchdog state
   pwdt_state_t state_q, state_d;
   logic [15:0] watchdog_counter_q, watchdog_counter_d;
   logic [7:0]  upper_byte_reload_q, upper_byte_reload_d;
   logic        prescale_select_q, prescale_select_d;
   logic        refresh_arm_bit_q, refresh_arm_bit_d;
   logic        watchdog_reset_flag_q, watchdog_reset_flag_d;
   logic [3:0]  pulse_q, pulse_d;        // internal reset pulse position
   logic        reset_out_q, reset_out_d;
   // combinational helpers
   logic        tick;                    // prescaled count enable
   logic        halt;                    // processor in a power saving mode
   logic        cfg_wr, ctl_wr;          // data phase writes per register
   logic        service;                 // valid refresh sequence completed
   logic        expire;                  // counter wraps this cycle
   logic        pre_clear;

   assign halt      = IDLE_MODE || POWER_DOWN;
   assign HREADYOUT = 1'b1;              // zero wait states, always ready
   assign HRESP     = 1'b0;              // always OKAY
   assign HRDATA    = rdata_q;
   assign WATCHDOG_RESET_OUT = reset_out_q;

   // restart the prescaler on service and whenever the watchdog is off or firing
   assign pre_clear = service || (state_q != PWDT_ACTIVE);

   pwdt_prescaler u_prescaler (
      .clk   (CLK),
      .rst_n (RST_N),
      .clear (pre_clear),
      .hold  (halt),
      .slow  (prescale_select_q),
      .tick  (tick)
   );

   // bus address phase: latch word writes; reads answer straight from next state
   always_comb begin
      wr_ph_d = 1'b0;
      addr_d  = addr_q;
      rdata_d = rdata_q;
      if (HSEL && HREADY && HTRANS[1]) begin
         addr_d  = HADDR[7:0];
         wr_ph_d = HWRITE && (HSIZE == 3'b010);   // sub-word writes are dropped
         if (!HWRITE) begin
            // next-state values so a read right behind a write sees that write
            case (HADDR[7:0])
               PWDT_OFF_CONFIG:  rdata_d = {23'h000000, prescale_select_d, upper_byte_reload_d};
               PWDT_OFF_CONTROL: rdata_d = {27'h0000000, 1'b0, (state_d != PWDT_OFF),
                                            watchdog_reset_flag_d, 1'b0, refresh_arm_bit_d};
               PWDT_OFF_COUNT:   rdata_d = {16'h0000, watchdog_counter_d};
               default:          rdata_d = 32'h00000000;   // unmapped reads zero
            endcase
         end
      end
   end

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         wr_ph_q <= 1'b0;
         addr_q  <= 8'h00;
         rdata_q <= 32'h00000000;
      end else begin
         wr_ph_q <= wr_ph_d;
         addr_q  <= addr_d;
         rdata_q <= rdata_d;
      end
   end

   // watchdog core next state
   always_comb begin
      cfg_wr  = wr_ph_q && (addr_q == PWDT_OFF_CONFIG);
      ctl_wr  = wr_ph_q && (addr_q == PWDT_OFF_CONTROL);
      // start only counts when the previous write armed it and this one does not re-arm
      service = ctl_wr && HWDATA[PWDT_CTL_START] && !HWDATA[PWDT_CTL_ARM]
                && refresh_arm_bit_q && (state_q == PWDT_ACTIVE);
      expire  = (state_q == PWDT_ACTIVE) && tick && !service
                && (watchdog_counter_q == PWDT_COUNT_TOP);
      state_d               = state_q;
      watchdog_counter_d    = watchdog_counter_q;
      upper_byte_reload_d   = upper_byte_reload_q;
      prescale_select_d     = prescale_select_q;
      refresh_arm_bit_d     = refresh_arm_bit_q;
      watchdog_reset_flag_d = watchdog_reset_flag_q;
      pulse_d               = pulse_q;
      reset_out_d           = 1'b0;
      // any word write either arms or breaks the sequence; reads and sub-word writes leave it alone
      if (wr_ph_q) begin
         refresh_arm_bit_d = ctl_wr && HWDATA[PWDT_CTL_ARM] && !HWDATA[PWDT_CTL_START];
      end
      if (cfg_wr) begin
         upper_byte_reload_d = HWDATA[PWDT_CFG_RELOAD_LSB +: 8];
         prescale_select_d   = HWDATA[PWDT_CFG_PRESCALE];
      end
      if (ctl_wr && HWDATA[PWDT_CTL_FLAG]) begin
         watchdog_reset_flag_d = 1'b0;     // write one clears
      end
      case (state_q)
         PWDT_ACTIVE: begin
            if (service) begin
               watchdog_counter_d = {upper_byte_reload_q, PWDT_LOW_CLEAR};
            end else if (tick) begin
               watchdog_counter_d = watchdog_counter_q + 16'h0001;
            end
            if (expire) begin
               state_d               = PWDT_FIRE;
               watchdog_reset_flag_d = 1'b1;   // set placed last so it beats a clear
               reset_out_d           = 1'b1;
               pulse_d               = 4'h0;
            end else if (ctl_wr && HWDATA[PWDT_CTL_DISABLE]) begin
               state_d = PWDT_OFF;
            end
         end
         PWDT_OFF: begin
            // no path back to active except a reset
            state_d = PWDT_OFF;
         end
         PWDT_FIRE: begin
            // hold the system reset, then restart the watchdog from defaults
            reset_out_d         = (pulse_q != PWDT_PULSE_LAST);
            pulse_d             = pulse_q + 4'h1;
            watchdog_counter_d  = PWDT_COUNT_RST;
            upper_byte_reload_d = PWDT_RELOAD_RST;
            prescale_select_d   = PWDT_PRESCALE_RST;
            refresh_arm_bit_d   = 1'b0;
            if (pulse_q == PWDT_PULSE_LAST) begin
               state_d = PWDT_ACTIVE;
            end
         end
         default: begin
            state_d = PWDT_ACTIVE;
         end
      endcase
   end

   // core registers; the flag is cleared only by the external reset or software
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         state_q               <= PWDT_ACTIVE;
         watchdog_counter_q    <= PWDT_COUNT_RST;
         upper_byte_reload_q   <= PWDT_RELOAD_RST;
         prescale_select_q     <= PWDT_PRESCALE_RST;
         refresh_arm_bit_q     <= 1'b0;
         watchdog_reset_flag_q <= 1'b0;
         pulse_q               <= 4'h0;
         reset_out_q           <= 1'b0;
      end else begin
         state_q               <= state_d;
         watchdog_counter_q    <= watchdog_counter_d;
         upper_byte_reload_q   <= upper_byte_reload_d;
         prescale_select_q     <= prescale_select_d;
         refresh_arm_bit_q     <= refresh_arm_bit_d;
         watchdog_reset_flag_q <= watchdog_reset_flag_d;
         pulse_q               <= pulse_d;
         reset_out_q           <= reset_out_d;
      end
   end

   // checking helpers: cycles since service and whether that period is the shortest one
   localparam int MIN_CYC = PWDT_MIN_PERIOD_CYC;
   logic [15:0] since_q;
   logic        fast_q;
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         since_q <= 16'h0000;
         fast_q  <= 1'b0;
      end else begin
         since_q <= service ? 16'h0001 : since_q + 16'h0001;
         if (service) begin
            fast_q <= (upper_byte_reload_q == 8'hff) && !prescale_select_q && !halt;
         end else if (halt || prescale_select_q || state_q != PWDT_ACTIVE) begin
            fast_q <= 1'b0;
         end
      end
   end

   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_N);

   chk_reload_upper: assert property (service |=> watchdog_counter_q[15:8] == $past(upper_byte_reload_q))
      else $error("service did not load the reload byte");
   chk_low_cleared: assert property (service |=> watchdog_counter_q[7:0] == 8'h00)
      else $error("service did not clear the low byte");
   chk_count_step: assert property ((state_q == PWDT_ACTIVE) && tick && !service && !expire
      |=> watchdog_counter_q == $past(watchdog_counter_q) + 16'h0001)
      else $error("counter did not advance on a tick");
   // both cycles after a tick must be free of hold, clear and ratio change, or the gap is legally longer
   chk_fast_tick: assert property ((state_q == PWDT_ACTIVE) && !halt && !prescale_select_q && tick
      ##1 (!halt && !prescale_select_q && !service && state_q == PWDT_ACTIVE)
      ##1 (!halt && !prescale_select_q && !service && state_q == PWDT_ACTIVE) |-> tick)
      else $error("divide by two tick spacing wrong");
   chk_wrap_fires: assert property (expire |=> ((state_q == PWDT_FIRE) && WATCHDOG_RESET_OUT) [*8]
      ##1 (!WATCHDOG_RESET_OUT && state_q == PWDT_ACTIVE))
      else $error("wrap did not give an eight cycle reset");
   chk_wrap_event: assert property ($rose(WATCHDOG_RESET_OUT) |-> $past(watchdog_counter_q) == 16'hffff)
      else $error("reset without counter wrap");
   chk_min_period: assert property (expire && fast_q |-> since_q == MIN_CYC)
      else $error("shortest period is not 512 cycles");
   chk_flag_set: assert property (expire |=> watchdog_reset_flag_q [*8])
      else $error("reset flag not set on expiry");
   chk_stays_off: assert property (state_q == PWDT_OFF |=> state_q == PWDT_OFF && !WATCHDOG_RESET_OUT)
      else $error("watchdog came back on after disable");
   chk_idle_halt: assert property (halt && state_q == PWDT_ACTIVE && !service |=> $stable(watchdog_counter_q))
      else $error("counter moved while halted");
   // a start write with no arm in front must not restart the low byte; 00 and ff excluded since a tick can reach 00
   chk_needs_arm: assert property (ctl_wr && HWDATA[PWDT_CTL_START] && !refresh_arm_bit_q
      && state_q == PWDT_ACTIVE && watchdog_counter_q[7:0] != 8'h00 && watchdog_counter_q[7:0] != 8'hff
      |=> watchdog_counter_q[7:0] != 8'h00)
      else $error("start write reloaded without an arm");

   cov_service: cover property (service);
   cov_expire:  cover property (expire);
   cov_disable: cover property (state_q == PWDT_ACTIVE ##1 state_q == PWDT_OFF);
   cov_halted:  cover property (halt && state_q == PWDT_ACTIVE);
endmodule

/* test_programmable_watchdog_timer.sv */
// self-checking bench for the watchdog with its AHB-Lite register slave
// assumes pwdt_top drives HREADYOUT, which is fed back as the bus hready
`timescale 1ns/10ps

module test_programmable_watchdog_timer;
   import pwdt_pkg::*;

   logic        CLK;                 // 25 MHz system clock
   logic        RST_N;               // external reset, active low
   logic        HSEL;                // slave select
   logic [31:0] HADDR;               // byte address
   logic [1:0]  HTRANS;              // transfer kind
   logic        HWRITE;              // write strobe
   logic [2:0]  HSIZE;               // always a word
   logic [31:0] HWDATA;              // write data
   logic        HREADY;              // bus hready, fed back from the slave
   logic [31:0] HRDATA;              // read data
   logic        HREADYOUT;           // slave ready
   logic        HRESP;               // slave response
   logic        IDLE_MODE;           // processor idle
   logic        POWER_DOWN;          // processor power-down
   logic        WATCHDOG_RESET_OUT;  // internal reset request
   int          n_mismatch;          // failed comparisons
   int          checked;             // comparisons made
   logic [31:0] d;                   // last read word
   logic [31:0] d2;                  // second read word
   logic [7:0]  r;                   // random reload
   int          n;                   // cycle counter

   // compare and count; four-state equality so an unknown never matches
   `define CHECK(got, exp) begin checked++; if ((got) !== (exp)) begin n_mismatch++; \
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (got), (exp)); end end

   assign HREADY = HREADYOUT;   // single slave, its ready is the bus ready

   pwdt_top u_pwdt_top (.CLK(CLK), .RST_N(RST_N), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
      .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADY), .HRDATA(HRDATA),
      .HREADYOUT(HREADYOUT), .HRESP(HRESP), .IDLE_MODE(IDLE_MODE), .POWER_DOWN(POWER_DOWN),
      .WATCHDOG_RESET_OUT(WATCHDOG_RESET_OUT));

   // free-running clock, half period 20 ns
   initial CLK = 1'b0;
   always #20 CLK = ~CLK;

   // verdict in one place, reached from the end or from any timeout
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // wait for hready at a rising edge, bounded so a stuck slave ends the run
   task automatic wait_ready();
      int k;
      k = 0;
      do begin
         @(posedge CLK);
         k++;
      end while (HREADY !== 1'b1 && k < 50);
      if (k >= 50) begin
         n_mismatch++;
         report_and_stop();
      end
   endtask

   // one single word transfer; entered just after a rising edge
   task automatic bus(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
                      output logic [31:0] rdata);
      HSEL   <= 1'b1;
      HADDR  <= {24'h000000, addr};
      HTRANS <= 2'b10;
      HWRITE <= wr;
      HSIZE  <= 3'b010;
      wait_ready();
      HTRANS <= 2'b00;
      HWDATA <= wdata;
      wait_ready();
      rdata = HRDATA;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      logic [31:0] x;
      bus(1'b1, a, v, x);
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      bus(1'b0, a, 32'h00000000, v);
   endtask

   // arm then start, two consecutive writes
   task automatic service();
      wr(PWDT_OFF_CONTROL, 32'h00000001);
      wr(PWDT_OFF_CONTROL, 32'h00000002);
   endtask

   task automatic idle_cycles(input int c);
      repeat (c) @(posedge CLK);
   endtask

   // expected cycles from a service to the wrap, from the reload byte and the ratio
   function automatic int exp_period(input logic [7:0] rel, input logic slow);
      int div;
      div = slow ? 128 : 2;
      return div * (65536 - 256 * int'(rel));
   endfunction

   // cycles from the service edge to the rise of the internal reset; entered at that edge
   task automatic time_to_fire(output int c);
      c = 0;
      while (WATCHDOG_RESET_OUT !== 1'b1 && c < 40000) begin
         @(negedge CLK);
         if (WATCHDOG_RESET_OUT !== 1'b1) c++;
      end
      if (c >= 40000) begin
         n_mismatch++;
         report_and_stop();
      end
   endtask

   // length of the internal reset pulse, counted in falling edges while it stands
   task automatic pulse_len(output int c);
      c = 0;
      while (WATCHDOG_RESET_OUT === 1'b1 && c < 50) begin
         @(negedge CLK);
         c++;
      end
      if (c >= 50) begin
         n_mismatch++;
         report_and_stop();
      end
   endtask

   initial begin
      n_mismatch = 0;
      checked = 0;
      RST_N = 1'b0;
      HSEL = 1'b0;
      HADDR = 32'h00000000;
      HTRANS = 2'b00;
      HWRITE = 1'b0;
      HSIZE = 3'b010;
      HWDATA = 32'h00000000;
      IDLE_MODE = 1'b0;
      POWER_DOWN = 1'b0;
      void'($urandom(37));
      repeat (3) @(posedge CLK);
      RST_N <= 1'b1;
      @(posedge CLK);
      // reset values: enabled, reload 00, prescale /2, flag clear
      rd(PWDT_OFF_CONFIG, d);  `CHECK(d, 32'h00000000)
      rd(PWDT_OFF_CONTROL, d); `CHECK(d, 32'h00000008)
      rd(8'h0c, d);            `CHECK(d, 32'h00000000)
      `CHECK(HRESP, 1'b0)
      `CHECK(HREADYOUT, 1'b1)
      $display("test reset values done");
      // random reloads: upper byte loaded, lower byte cleared then only a few ticks
      for (int i = 0; i < 8; i++) begin
         r = (i == 0) ? 8'h00 : 8'($urandom % 256);
         wr(PWDT_OFF_CONFIG, {24'h000000, r});
         service();
         rd(PWDT_OFF_COUNT, d);
         `CHECK(d[15:8], r)
         `CHECK(d[7:0] < 8'h04, 1'b1)
      end
      $display("test random service done");
      // slow prescaler: about 300 cycles give only two ticks
      wr(PWDT_OFF_CONFIG, 32'h000001ff);
      service();
      idle_cycles(300);
      rd(PWDT_OFF_COUNT, d);
      `CHECK(d[15:0] >= 16'hff02 && d[15:0] <= 16'hff03, 1'b1)
      $display("test slow prescale done");
      // broken patterns do not reload; a read between arm and start does not break it
      wr(PWDT_OFF_CONFIG, 32'h00000000);
      wr(PWDT_OFF_CONTROL, 32'h00000001);
      wr(PWDT_OFF_CONFIG, 32'h00000000);
      wr(PWDT_OFF_CONTROL, 32'h00000002);
      rd(PWDT_OFF_COUNT, d);   `CHECK(d[15:8], 8'hff)
      wr(PWDT_OFF_CONTROL, 32'h00000003);
      rd(PWDT_OFF_COUNT, d);   `CHECK(d[15:8], 8'hff)
      wr(PWDT_OFF_CONTROL, 32'h00000001);
      rd(PWDT_OFF_CONTROL, d);
      `CHECK(d[0], 1'b1)
      wr(PWDT_OFF_CONTROL, 32'h00000002);
      rd(PWDT_OFF_COUNT, d);   `CHECK(d[15:8], 8'h00)
      $display("test refresh pattern done");
      // shortest period: reload ff, /2 gives 512 cycles to the wrap
      wr(PWDT_OFF_CONFIG, 32'h000000ff);
      service();
      time_to_fire(n);
      `CHECK(n, PWDT_MIN_PERIOD_CYC)
      `CHECK(n, exp_period(8'hff, 1'b0))
      pulse_len(n);
      `CHECK(n, 8)
      @(posedge CLK);
      rd(PWDT_OFF_CONTROL, d); `CHECK(d[2], 1'b1)
      rd(PWDT_OFF_CONFIG, d);  `CHECK(d, 32'h00000000)
      wr(PWDT_OFF_CONTROL, 32'h00000004);
      rd(PWDT_OFF_CONTROL, d); `CHECK(d[2], 1'b0)
      // longest short-reload period: reload ff through the divide by 128
      wr(PWDT_OFF_CONFIG, 32'h000001ff);
      service();
      time_to_fire(n);
      `CHECK(n, PWDT_MAX_PERIOD_CYC)
      `CHECK(n, exp_period(8'hff, 1'b1))
      pulse_len(n);
      `CHECK(n, 8)
      @(posedge CLK);
      $display("test expiry done");
      // idle and power-down each freeze the counter
      for (int m = 0; m < 2; m++) begin
         IDLE_MODE  <= (m == 0);
         POWER_DOWN <= (m == 1);
         rd(PWDT_OFF_COUNT, d);
         idle_cycles(40);
         rd(PWDT_OFF_COUNT, d2);
         `CHECK(d2, d)
      end
      IDLE_MODE  <= 1'b0;
      POWER_DOWN <= 1'b0;
      idle_cycles(20);
      rd(PWDT_OFF_COUNT, d2);
      `CHECK(d2 != d, 1'b1)
      $display("test halt done");
      // disabled watchdog stays off; nothing turns it back on
      wr(PWDT_OFF_CONTROL, 32'h00000010);
      rd(PWDT_OFF_CONTROL, d); `CHECK(d[3], 1'b0)
      wr(PWDT_OFF_CONFIG, 32'h000000ff);
      service();
      n = 0;
      repeat (700) begin
         @(negedge CLK);
         if (WATCHDOG_RESET_OUT !== 1'b0) n++;
      end
      `CHECK(n, 0)
      @(posedge CLK);
      rd(PWDT_OFF_CONTROL, d); `CHECK(d[3], 1'b0)
      $display("test disable done");
      report_and_stop();
   end
endmodule
